// ==== logic/facc_pkg.sv ====
// package for the fast capture control block: control word layout, rates, carriers
// Notes on behaviour
// - bit 9 low: read strobes load/step counters
// - bit 10 low: host may read samples
// - bit 11 low: host may read trigger address
// - bit 12 low: host may write rate latch
// - bit 13 low: sweep strobe released
// - bit 14 low: video level load allowed
// - bit 4 high: bit 15 picks pit/peak
// - all clocks come from 24 MHz reference
// - rate spans 1 to 256 samples per bucket
// - peak/pit slow rate: first bucket sample stored
// - trigger latches address, starts post counter
// - write on until post terminal count
// - one trigger per arm low-to-high cycle
// - sweep strobe triggers, video mode uses video clock
// - bit 0 set: clocks run, memory not readable
// - word moves as high byte then low byte
// - bit 4 low selects sample detection
package facc_pkg;
  localparam int unsigned WRITE_BIT     = 0;
  localparam int unsigned ARM_BIT       = 1;
  localparam int unsigned VPOL_BIT      = 3;
  localparam int unsigned SAMPDIS_BIT   = 4;
  localparam int unsigned LDADDR_N_BIT  = 6;
  localparam int unsigned LDPOST_N_BIT  = 7;
  localparam int unsigned VTRIG_N_BIT   = 8;
  localparam int unsigned RDCLK_N_BIT   = 9;
  localparam int unsigned RDMEM_N_BIT   = 10;
  localparam int unsigned RDTRIG_N_BIT  = 11;
  localparam int unsigned RATE_N_BIT    = 12;
  localparam int unsigned RELEASE_N_BIT = 13;
  localparam int unsigned VLEVEL_N_BIT  = 14;
  localparam int unsigned PIT_BIT       = 15;
  localparam logic [15:0] CTRL_RESET    = 16'hfffe;  // all enables off, not writing
  localparam logic [14:0] ADDR_RESET    = 15'h0000;
  localparam logic [15:0] POST_TERMINAL = 16'hffff;
  localparam logic [15:0] POST_RESET    = 16'hffff;  // terminal: stopped after reset
  localparam logic [7:0]  RATE_RESET    = 8'h00;     // 1 sample per bucket
  localparam logic [7:0]  VLEVEL_RESET  = 8'h00;
  localparam int unsigned REF_MHZ       = 24;
  localparam int unsigned MAX_RATE_MHZ  = 12;
  localparam int unsigned CLK_MHZ       = 100;
  // reference enable: phase accumulator step per system cycle, out of CLK_MHZ
  localparam logic [7:0]  REF_STEP      = 8'(REF_MHZ);
  localparam logic [7:0]  REF_WRAP      = 8'(CLK_MHZ);
  localparam int unsigned REF_PER_SAMP  = REF_MHZ / MAX_RATE_MHZ;

  typedef enum logic [1:0] {
    FACC_DET_SAMPLE = 2'b00,
    FACC_DET_PEAK   = 2'b01,
    FACC_DET_PIT    = 2'b10
  } facc_det_t;

  typedef struct packed {
    logic      writing;
    logic      armed;
    logic      vid_neg;
    logic      vid_en;
    logic      rdclk_en;
    logic      rdmem_en;
    logic      rdtrig_en;
    logic      rate_wr_en;
    logic      release_en;
    logic      vlevel_en;
    logic      ld_addr;
    logic      ld_post;
    facc_det_t det;
  } facc_ctrl_t;

  typedef struct packed {
    logic       we;      // one-cycle sample memory write
    logic       first;   // first sample of bucket
    logic [14:0] addr;
    logic [7:0] data;
  } facc_mem_t;
endpackage

// ==== logic/facc_rate_gen.sv ====
// sample rate generator: 24 MHz enable from system clock, then bucket divider
module facc_rate_gen (
  input  wire logic       mclk_in,      // 100 MHz system clock
  input  wire logic       rst_n_in,     // sync reset, active low
  input  wire logic       run_in,       // sample clock runs only in write mode; reference enable free-runs
  input  wire logic [7:0] rate_in,      // samples per bucket minus one
  output logic            ref_en_out,   // 24 MHz enable pulse
  output logic            samp_en_out,  // 12 MHz sample enable
  output logic            first_out     // sample is first of its bucket
);
  logic [7:0] acc;
  logic       ph;
  logic [7:0] cnt;
  wire  [8:0] acc_sum   = {1'b0, acc} + {1'b0, facc_pkg::REF_STEP};
  wire        ref_tick  = acc_sum >= {1'b0, facc_pkg::REF_WRAP};
  wire        samp_tick = ref_tick && ph && run_in;

  // fractional divider: every clock derives from one 24 MHz tick stream
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      acc <= 8'h00;
      ref_en_out <= 1'b0;
    end else begin
      acc <= ref_tick ? 8'(acc_sum - {1'b0, facc_pkg::REF_WRAP}) : acc_sum[7:0];
      ref_en_out <= ref_tick;
    end
  end

  // halve to the 12 MHz sample rate; bucket counter sets 1..256 samples
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !run_in) begin
      ph <= 1'b0;
      cnt <= 8'h00;
      samp_en_out <= 1'b0;
      first_out <= 1'b0;
    end else begin
      if (ref_tick)
        ph <= ~ph;
      samp_en_out <= samp_tick;
      if (samp_tick) begin
        first_out <= (cnt == 8'h00);  // count zero marks bucket start
        cnt <= (cnt == rate_in) ? 8'h00 : 8'(cnt + 8'h01);
      end
    end
  end

  sample_spacing_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    samp_en_out |=> !samp_en_out) else $error("sample enables back to back");
  one_sample_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (rate_in == 8'h00 && samp_en_out && $stable(rate_in)) |-> first_out)
    else $error("single-sample bucket not marked first");
endmodule

// ==== logic/facc_capture.sv ====
// capture control: byte port, control word, counters, trigger and detector
module facc_capture (
  input  wire logic        mclk_in,          // 100 MHz clock
  input  wire logic        rst_n_in,         // sync reset, active low
  input  wire logic        port_select_line_in, // 0 control word, 1 data port
  input  wire logic        msb_strb_in,      // high byte strobe from host
  input  wire logic        lsb_strb_in,      // low byte strobe from host
  input  wire logic [7:0]  host_data_in,     // host data bus in
  output logic [7:0]       host_data_out,    // host data bus out
  output logic             host_data_oe_n_out, // low while driving the bus
  input  wire logic [7:0]  flash_converter_in, // converter sample
  input  wire logic        sweep_strobe_in,  // sweep strobe pin
  input  wire logic        video_trigger_clock_in, // video trigger pin
  output logic             sweep_strobe_release_out, // release sweep strobe
  output logic             mem_we_out,       // sample memory write strobe
  output logic [14:0]      mem_addr_out,     // sample memory address
  output logic [7:0]       mem_wdata_out,    // sample memory write data
  input  wire logic [7:0]  mem_rdata_in,     // sample memory read data
  output logic [7:0]       rate_out,         // rate latch contents
  output logic [7:0]       video_level_out,  // video trigger level
  output logic             triggered_out     // trigger seen, post count on
);
  // pin synchronisers; first stage read only by the second
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] sync3;
  logic [7:0] data_s1;
  logic [7:0] data_s2;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      sync3 <= 5'h00;
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
    end else begin
      sync1 <= {msb_strb_in, lsb_strb_in, port_select_line_in, sweep_strobe_in, video_trigger_clock_in};
      sync2 <= sync1;
      sync3 <= sync2;
      data_s1 <= host_data_in;
      data_s2 <= data_s1;
    end
  end
  // host data lags by the same two flops as the strobes, so a byte and its strobe edge line up
  wire [7:0] host_byte = data_s2;
  wire msb_fall = sync3[4] && !sync2[4];  // strobes active low, act on assertion
  wire lsb_fall = sync3[3] && !sync2[3];
  wire sel_hi   = sync2[2];
  wire swp_rise = sync2[1] && !sync3[1];
  wire vid_rise = sync2[0] && !sync3[0];

  // control word and decode
  logic [15:0] ctrl;
  logic [7:0]  hi_byte;
  facc_pkg::facc_ctrl_t c;
  assign c.writing    = ctrl[facc_pkg::WRITE_BIT];
  assign c.armed      = ctrl[facc_pkg::ARM_BIT];
  assign c.vid_neg    = ctrl[facc_pkg::VPOL_BIT];
  assign c.vid_en     = !ctrl[facc_pkg::VTRIG_N_BIT];
  assign c.rdclk_en   = !ctrl[facc_pkg::RDCLK_N_BIT];
  assign c.rdmem_en   = !ctrl[facc_pkg::RDMEM_N_BIT] && !c.writing;
  assign c.rdtrig_en  = !ctrl[facc_pkg::RDTRIG_N_BIT];
  assign c.rate_wr_en = !ctrl[facc_pkg::RATE_N_BIT];
  assign c.release_en = !ctrl[facc_pkg::RELEASE_N_BIT];
  assign c.vlevel_en  = !ctrl[facc_pkg::VLEVEL_N_BIT];
  assign c.ld_addr    = !ctrl[facc_pkg::LDADDR_N_BIT];
  assign c.ld_post    = !ctrl[facc_pkg::LDPOST_N_BIT];
  // bit 4 low picks sample mode, else bit 15 picks pit or peak
  assign c.det = !ctrl[facc_pkg::SAMPDIS_BIT] ? facc_pkg::FACC_DET_SAMPLE :
                 ctrl[facc_pkg::PIT_BIT] ? facc_pkg::FACC_DET_PIT : facc_pkg::FACC_DET_PEAK;

  // high byte held until the low byte completes the word
  wire        wr_ctrl = lsb_fall && !sel_hi;
  wire        wr_data = lsb_fall && sel_hi && !c.writing;
  wire [15:0] word    = {hi_byte, host_byte};
  // read clock pulses only when enabled; low-byte data port reads step the address while the post counter is off terminal
  wire        rd_step = lsb_fall && sel_hi && c.writing == 1'b0 && c.rdclk_en && c.rdmem_en;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ctrl <= facc_pkg::CTRL_RESET;
      hi_byte <= 8'h00;
    end else begin
      if (msb_fall)
        hi_byte <= host_byte;
      if (wr_ctrl)
        ctrl <= word;
    end
  end

  // rate generator
  logic samp_en;
  logic first;
  facc_rate_gen u_rate (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .run_in      (c.writing),
    .rate_in     (rate_out),
    .ref_en_out  (),
    .samp_en_out (samp_en),
    .first_out   (first)
  );

  // trigger: one per arm cycle source by mode
  logic arm_d;
  logic fired;
  logic [14:0] addr;
  logic [15:0] post;
  logic [14:0] trig_addr;
  wire vid_edge = c.vid_neg ? (!sync2[0] && sync3[0]) : vid_rise;
  wire trig_src = c.vid_en ? vid_edge : swp_rise;
  wire trig     = trig_src && c.armed && arm_d && !fired && c.writing;
  wire post_tc  = post == facc_pkg::POST_TERMINAL;
  wire step_w   = samp_en && c.writing && !(triggered_out && post_tc);
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      arm_d <= 1'b0;
      fired <= 1'b0;
      triggered_out <= 1'b0;
      trig_addr <= facc_pkg::ADDR_RESET;
    end else begin
      arm_d <= c.armed;
      if (!c.armed)
        fired <= 1'b0;             // disarm re-opens trigger
      else if (trig)
        fired <= 1'b1;
      if (trig) begin
        trig_addr <= addr;
        triggered_out <= 1'b1;
      end else if (!c.writing)
        triggered_out <= 1'b0;
    end
  end

  // address and post-trigger counters
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      addr <= facc_pkg::ADDR_RESET;
      post <= facc_pkg::POST_RESET;
    end else begin
      if (wr_data && c.rdclk_en && c.ld_addr)
        addr <= word[14:0];
      else if (step_w || (rd_step && !post_tc))
        addr <= 15'(addr + 15'h0001);  // circular over 32 K
      if (wr_data && c.rdclk_en && c.ld_post)
        post <= word;
      else if (samp_en && triggered_out && !post_tc)
        post <= 16'(post + 16'h0001);  // counts after trigger
    end
  end

  // detector: sample, or running peak/pit with first sample forced in
  logic [7:0] det_val;
  wire [7:0]  smp    = flash_converter_in;
  wire        better = (c.det == facc_pkg::FACC_DET_PIT) ? (smp < det_val) : (smp > det_val);
  wire        take   = first || c.det == facc_pkg::FACC_DET_SAMPLE || better;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      det_val <= 8'h00;
      mem_we_out <= 1'b0;
      mem_addr_out <= facc_pkg::ADDR_RESET;
      mem_wdata_out <= 8'h00;
    end else begin
      if (samp_en && take)
        det_val <= smp;
      mem_we_out <= step_w && take;
      mem_addr_out <= addr;
      mem_wdata_out <= smp;
    end
  end

  // latches loaded from the data port and host read path
  wire rd_cycle = sel_hi && !c.writing && (c.rdmem_en || c.rdtrig_en);
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rate_out <= facc_pkg::RATE_RESET;
      video_level_out <= facc_pkg::VLEVEL_RESET;
      sweep_strobe_release_out <= 1'b0;
      host_data_out <= 8'h00;
      host_data_oe_n_out <= 1'b1;
    end else begin
      if (wr_data && c.rate_wr_en)
        rate_out <= host_byte;
      if (wr_data && c.vlevel_en)
        video_level_out <= host_byte;
      sweep_strobe_release_out <= c.release_en;
      host_data_oe_n_out <= !rd_cycle;
      if (c.rdtrig_en)
        // high byte while the msb strobe is asserted (low)
        host_data_out <= !sync2[4] ? {1'b0, trig_addr[14:8]} : trig_addr[7:0];
      else
        host_data_out <= mem_rdata_in;
    end
  end

  no_mem_read_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ctrl[facc_pkg::WRITE_BIT] |=> host_data_oe_n_out) else $error("bus driven in write mode");
  trig_latch_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    trig |=> trig_addr == $past(addr)) else $error("trigger address not latched");
  // the latched address may not move again until a disarm
  single_trig_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    fired && c.armed |=> fired && $stable(trig_addr)) else $error("retrigger without disarm");
  post_stop_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    triggered_out && post_tc |=> !mem_we_out) else $error("write after terminal count");
  rate_block_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !c.rate_wr_en |=> $stable(rate_out)) else $error("rate latch written while blocked");
  release_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ##1 sweep_strobe_release_out == !$past(ctrl[facc_pkg::RELEASE_N_BIT])) else $error("release wrong");
  ctrl_pair_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    wr_ctrl |=> ctrl == $past(word)) else $error("control word not assembled");
  addr_idle_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (!c.writing && !c.rdclk_en) |=> $stable(addr)) else $error("address moved with read clock off");

  // step sequences: a host read that must post-increment, a sample tick that must count
  sequence read_pulse_s;
    rd_step && !post_tc && !c.ld_addr;
  endsequence
  sequence post_tick_s;
    triggered_out && samp_en && !post_tc;
  endsequence
  read_step_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    read_pulse_s |=> addr == 15'($past(addr) + 15'h0001)) else $error("address not stepped after read");
  post_count_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    post_tick_s |=> post == 16'($past(post) + 16'h0001)) else $error("post counter not counting");
  // in video mode a sweep strobe edge alone must never fire the trigger
  video_src_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    c.vid_en && swp_rise && !vid_edge |-> !trig) else $error("sweep strobe fired in video mode");
endmodule

// ==== tb/facc_host_model.sv ====
// host controller model: master of the byte-wide strobed port
module facc_host_model (
  input  wire logic       mclk_in,    // system clock
  input  wire logic [7:0] rd_data_in, // bus data from device
  output logic            sel_out,    // port select line
  output logic            msb_n_out,  // high byte strobe, active low
  output logic            lsb_n_out,  // low byte strobe, active low
  output logic [7:0]      data_out    // bus data to device
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sel_out = 1'b0;
    msb_n_out = 1'b1;
    lsb_n_out = 1'b1;
    data_out = 8'h00;
  end
  // one strobe: low 4 clocks, data held 5 more, then the bus is let go
  task automatic strobe(input logic hi, input logic [7:0] d, output logic [7:0] q);
    data_out <= d;
    if (hi) msb_n_out <= 1'b0;
    else lsb_n_out <= 1'b0;
    repeat (4) @(posedge mclk_in);
    q = rd_data_in;
    msb_n_out <= 1'b1;
    lsb_n_out <= 1'b1;
    repeat (5) @(posedge mclk_in);
    data_out <= ~d;  // released bus must not keep the old byte
    @(posedge mclk_in);
  endtask
  // select settles through the 2 FF sync before any strobe
  task automatic put_word(input logic sel, input logic [15:0] w);
    logic [7:0] q;
    sel_out <= sel;
    repeat (3) @(posedge mclk_in);
    strobe(1'b1, w[15:8], q);
    strobe(1'b0, w[7:0], q);
  endtask
  // read of the latch or samples once out of write mode
  task automatic get_byte(input logic sel, input logic hi, output logic [7:0] q);
    sel_out <= sel;
    repeat (4) @(posedge mclk_in);
    strobe(hi, 8'h00, q);
  endtask
endmodule

// ==== tb/fast_adc_capture_control_tb.sv ====
// testbench for the fast capture control block
module fast_adc_capture_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_in  = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        sel, msb_n, lsb_n, oe_n, rel, we, trig;
  logic        sweep    = 1'b0;
  logic        up       = 1'b0;
  logic        video_trigger_clock     = 1'b0;
  logic        trig_d   = 1'b0;
  logic [14:0] trig_at  = 15'h0000;
  logic [7:0]  hd, hq, rate, level, wd;
  logic [7:0]  flash    = 8'h80;
  logic [14:0] addr;
  int          num_errors = 0;
  int          n_compared = 0;
  int          n_we       = 0;
  always #5 mclk_in = ~mclk_in;
  // converter input ramps every cycle so peak and pit see no gain
  always @(posedge mclk_in) flash <= up ? flash + 8'h01 : flash - 8'h01;
  always @(posedge mclk_in) if (we === 1'b1) n_we <= n_we + 1;
  // address on the memory bus when the trigger flag rises: the sample taken at the trigger
  always @(posedge mclk_in) begin
    trig_d <= trig;
    if (trig === 1'b1 && trig_d === 1'b0) trig_at <= addr;
  end
  facc_capture DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .port_select_line_in(sel),
    .msb_strb_in(msb_n), .lsb_strb_in(lsb_n), .host_data_in(hd), .host_data_out(hq),
    .host_data_oe_n_out(oe_n), .flash_converter_in(flash), .sweep_strobe_in(sweep),
    .video_trigger_clock_in(video_trigger_clock), .sweep_strobe_release_out(rel), .mem_we_out(we),
    .mem_addr_out(addr), .mem_wdata_out(wd), .mem_rdata_in(8'ha5), .rate_out(rate),
    .video_level_out(level), .triggered_out(trig));
  facc_host_model host (.mclk_in(mclk_in), .rd_data_in(hq), .sel_out(sel),
    .msb_n_out(msb_n), .lsb_n_out(lsb_n), .data_out(hd));
  // compare tasks, one per kind of result
  task automatic chk_bit(input string n, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_count(input string n, input int lo, input int hi, input int g);
    n_compared++;
    if (g < lo || g > hi) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic count_we(input int cyc, output int c);
    int c0;
    c0 = n_we;
    repeat (cyc) @(posedge mclk_in);
    c = n_we - c0;
  endtask
  task automatic t_reset;
    chk_byte("rate reset", 8'h00, rate);
    chk_byte("level reset", 8'h00, level);
    chk_bit("release reset", 1'b0, rel);
    chk_bit("oe_n reset", 1'b1, oe_n);
    chk_bit("trig reset", 1'b0, trig);
    $display("test reset done");
  endtask
  // a swapped byte order would leave bit 13 high
  task automatic t_word;
    host.put_word(1'b0, 16'hdffe);
    chk_bit("release", 1'b1, rel);
    host.put_word(1'b0, 16'hfffe);
    chk_bit("release off", 1'b0, rel);
    $display("test word done");
  endtask
  task automatic t_latch;
    host.put_word(1'b0, 16'heffe);
    host.put_word(1'b1, 16'h1205);
    chk_byte("rate", 8'h05, rate);
    chk_byte("level kept", 8'h00, level);
    host.put_word(1'b0, 16'hbffe);
    host.put_word(1'b1, 16'h3442);
    chk_byte("level", 8'h42, level);
    chk_byte("rate kept", 8'h05, rate);
    $display("test latch done");
  endtask
  // post counter is loaded off terminal first, else writes stop as soon as the trigger fires
  task automatic t_rates;
    int c;
    host.put_word(1'b0, 16'hfd7e);
    host.put_word(1'b1, 16'hfff0);
    host.put_word(1'b0, 16'heffe);
    host.put_word(1'b1, 16'h0001);
    count_we(500, c);
    chk_count("idle writes", 0, 0, c);
    host.put_word(1'b0, 16'h7fdd);
    count_we(1000, c);
    chk_count("peak writes", 59, 65, c);
    host.put_word(1'b0, 16'hffdd);
    up <= 1'b1;
    count_we(1000, c);
    chk_count("pit writes", 59, 65, c);
    host.put_word(1'b0, 16'heffe);
    host.put_word(1'b1, 16'h0000);
    host.put_word(1'b0, 16'hffcd);
    count_we(1000, c);
    chk_count("sample writes", 119, 121, c);
    $display("test rates done");
  endtask
  task automatic t_trigger;
    int c;
    sweep <= 1'b1;
    repeat (20) @(posedge mclk_in);
    sweep <= 1'b0;
    repeat (20) @(posedge mclk_in);
    chk_bit("unarmed trig", 1'b0, trig);
    host.put_word(1'b0, 16'hffcf);
    sweep <= 1'b1;
    count_we(300, c);
    chk_bit("armed trig", 1'b1, trig);
    chk_count("post writes", 15, 18, c);
    count_we(300, c);
    chk_count("after stop", 0, 0, c);
    sweep <= 1'b0;
    $display("test trigger done");
  endtask
  // post counter moved off terminal first, else the read clock cannot step the address
  task automatic t_step;
    logic [7:0] q;
    host.put_word(1'b0, 16'hfd7c);
    host.put_word(1'b1, 16'h0000);
    host.put_word(1'b0, 16'hfdbc);
    host.put_word(1'b1, 16'h0123);
    chk_count("addr load", 32'h00000123, 32'h00000123, addr);
    host.put_word(1'b0, 16'hf9fc);
    host.get_byte(1'b1, 1'b0, q);
    chk_byte("step read", 8'ha5, q);
    chk_count("addr step", 32'h00000124, 32'h00000124, addr);
    $display("test step done");
  endtask
  // a second video edge without disarm must leave the latched address alone
  task automatic t_video;
    host.put_word(1'b0, 16'hffcc);
    host.put_word(1'b0, 16'hfec7);
    sweep <= 1'b1;
    repeat (20) @(posedge mclk_in);
    chk_bit("sweep in video", 1'b0, trig);
    sweep <= 1'b0;
    video_trigger_clock <= 1'b1;
    repeat (20) @(posedge mclk_in);
    chk_bit("video trig", 1'b1, trig);
    video_trigger_clock <= 1'b0;
    repeat (20) @(posedge mclk_in);
    video_trigger_clock <= 1'b1;
    repeat (20) @(posedge mclk_in);
    video_trigger_clock <= 1'b0;
    $display("test video done");
  endtask
  task automatic t_read;
    logic [15:0] w[4] = '{16'hfbfc, 16'hfffc, 16'hf7fc, 16'hfbfd};
    logic        e[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0]  q;
    for (int i = 0; i < 4; i++) begin
      host.put_word(1'b0, w[i]);
      host.get_byte(1'b1, 1'b1, q);
      chk_bit("oe_n", e[i], oe_n);
      if (i == 0) chk_byte("mem read", 8'ha5, q);
      if (i == 2) chk_byte("trig addr hi", {1'b0, trig_at[14:8]}, q);
      if (i == 2) begin
        host.get_byte(1'b1, 1'b0, q);
        chk_byte("trig addr lo", trig_at[7:0], q);
      end
    end
    $display("test read done");
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    t_reset();
    t_word();
    t_latch();
    t_rates();
    t_trigger();
    t_step();
    t_video();
    t_read();
    end_of_test();
  end
  // tests need about 4900 cycles; a hang is cut off well beyond that
  initial begin
    repeat (30000) @(posedge mclk_in);
    num_errors++;
    end_of_test();
  end
endmodule
